// [src/adw_conv_done_irq.sv]
// Conversion-done flag, interrupt request and sleep wake sequencing
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Conversion end sets the done flag
// - Flag sets regardless of interrupt enable
// - Only software clears the done flag
// - Request needs flag and enable both
// - Interrupt works awake and asleep alike
// - Enabled interrupt wakes the sleeping core
// - Instruction after sleep always runs first
// - Then vector to ISR if global and peripheral enables both set
module adw_conv_done_irq (
	input  wire logic           core_clk,
	input  wire logic           sys_rst,
	input  wire logic           convComplete,
	input  wire adw_pkg::adw_sw_s swAccess,
	input  wire logic           sleepExec,
	input  wire logic           instrRetired,
	input  wire logic           globalIrqEnable,
	input  wire logic           periphIrqEnable,
	output logic                convDoneFlag,
	output logic                convDoneIrqEnable,
	output adw_pkg::adw_core_s  coreCtrl
);
	import adw_pkg::*;

	// Done flag, kept in its own cell
	logic       flagNow;

	// Per-source enable
	logic       enable_reg;
	logic       enable_next;

	// Request and the gate for vectoring
	logic       request;
	logic       vectorAllowed;

	// Core sequencer
	adw_state_e state_reg;
	adw_state_e state_next;

	// Registered core-side strobes
	adw_core_s  ctrl_reg;
	adw_core_s  ctrl_next;

	// Event is taken on every cycle, sleep or not, so no completion is lost
	adw_flag_cell uFlag (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.setEvent (convComplete),
		.swWrite  (swAccess.flagWrite),
		.swData   (swAccess.flagData),
		.flag     (flagNow)
	);

	// Software write only; hardware never touches the enable
	always_comb begin
		enable_next = enable_reg;
		if (swAccess.enableWrite) begin
			enable_next = swAccess.enableData;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			enable_reg <= IRQ_ENABLE_RST;
		end else begin
			enable_reg <= enable_next;
		end
	end

	// Per-source request; global enable deliberately left out of wake
	assign request = flagNow & enable_reg;

	// Both enables gate vectoring only, never the wake
	assign vectorAllowed = globalIrqEnable & periphIrqEnable;

	// Sequencer as seen from the core around a sleep instruction
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ADW_RUN: begin
				if (sleepExec) begin
					// A pending request turns the sleep into a no-op
					if (request) begin
						state_next = ADW_NEXT;
					end else begin
						state_next = ADW_SLEEP;
					end
				end else if (request && vectorAllowed) begin
					state_next = ADW_VECTOR;
				end else begin
					state_next = ADW_RUN;
				end
			end

			ADW_SLEEP: begin
				// Wake needs only the per-source request
				if (request) begin
					state_next = ADW_NEXT;
				end else begin
					state_next = ADW_SLEEP;
				end
			end

			ADW_NEXT: begin
				// The following instruction retires before any vectoring
				if (!instrRetired) begin
					state_next = ADW_NEXT;
				end else if (request && vectorAllowed) begin
					state_next = ADW_VECTOR;
				end else begin
					state_next = ADW_RUN;
				end
			end

			ADW_VECTOR: begin
				state_next = ADW_RUN;
			end

			default: begin
				state_next = ADW_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ADW_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// Strobes decode the next state so they leave flip-flops
	always_comb begin
		ctrl_next            = '0;
		ctrl_next.irqRequest = request;
		case (state_next)
			ADW_RUN: begin
				ctrl_next.wakeRequest = 1'b0;
				ctrl_next.fetchNext   = 1'b0;
				ctrl_next.vectorToIsr = 1'b0;
				ctrl_next.asleep      = 1'b0;
			end

			ADW_SLEEP: begin
				ctrl_next.wakeRequest = 1'b0;
				ctrl_next.fetchNext   = 1'b0;
				ctrl_next.vectorToIsr = 1'b0;
				ctrl_next.asleep      = 1'b1;
			end

			ADW_NEXT: begin
				// Only a way out of sleep is a wake, not a skipped sleep
				ctrl_next.wakeRequest = (state_reg == ADW_SLEEP);
				ctrl_next.fetchNext   = 1'b1;
				ctrl_next.vectorToIsr = 1'b0;
				ctrl_next.asleep      = 1'b0;
			end

			ADW_VECTOR: begin
				ctrl_next.wakeRequest = 1'b0;
				ctrl_next.fetchNext   = 1'b0;
				ctrl_next.vectorToIsr = 1'b1;
				ctrl_next.asleep      = 1'b0;
			end

			default: begin
				ctrl_next.wakeRequest = 1'b0;
				ctrl_next.fetchNext   = 1'b0;
				ctrl_next.vectorToIsr = 1'b0;
				ctrl_next.asleep      = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Outputs straight from registers
	assign convDoneFlag      = flagNow;
	assign convDoneIrqEnable = enable_reg;
	assign coreCtrl          = ctrl_reg;
endmodule
`default_nettype wire

// [shared/adw_pkg.sv]
// Package for the conversion-done interrupt and wake logic
package adw_pkg;
	localparam logic CONV_DONE_FLAG_RST = 1'b0;
	localparam logic IRQ_ENABLE_RST     = 1'b0;
	localparam int   FLAG_BIT_POS       = 6;
	localparam int   ENABLE_BIT_POS     = 6;

	// Core-side software access to the flag and enable bits
	typedef struct packed {
		logic flagWrite;
		logic flagData;
		logic enableWrite;
		logic enableData;
	} adw_sw_s;

	// Core sequencing state around sleep and wake
	typedef enum logic [3:0] {
		ADW_RUN    = 4'h1,
		ADW_SLEEP  = 4'h2,
		ADW_NEXT   = 4'h4,
		ADW_VECTOR = 4'h8
	} adw_state_e;

	typedef struct packed {
		logic irqRequest;
		logic wakeRequest;
		logic fetchNext;
		logic vectorToIsr;
		logic asleep;
	} adw_core_s;
endpackage

// [src/adw_flag_cell.sv]
// Sticky event flag with software write, set wins over clear
`timescale 1ns/100ps
`default_nettype none
module adw_flag_cell (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic setEvent,
	input  wire logic swWrite,
	input  wire logic swData,
	output logic      flag
);
	import adw_pkg::*;

	logic flag_reg;
	logic flag_next;

	always_comb begin
		flag_next = flag_reg;
		if (swWrite)
			flag_next = swData;
		// Hardware only sets, never clears; a set in the clear cycle wins
		if (setEvent)
			flag_next = 1'b1;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			flag_reg <= CONV_DONE_FLAG_RST;
		else
			flag_reg <= flag_next;
	end

	assign flag = flag_reg;
endmodule
`default_nettype wire

// [test/adw_core_model.sv]
// Core-side model: issues sleep and retires the instruction after wake
`timescale 1ns/100ps
`default_nettype none
module adw_core_model (
	input  wire logic core_clk,
	input  wire logic goSleep,
	input  wire logic fetchNext,
	output logic      sleepExec = 1'b0,
	output logic      instrRetired = 1'b0
);
	always @(posedge core_clk) begin
		sleepExec <= goSleep;
		instrRetired <= fetchNext && !instrRetired;
	end
endmodule
`default_nettype wire

// [test/adw_conv_done_irq_chk.sv]
// Checker for the done flag, request and wake sequencing
`timescale 1ns/100ps
`default_nettype none
module adw_conv_done_irq_chk import adw_pkg::*; (
	input wire logic      core_clk,
	input wire logic      sys_rst,
	input wire logic      convComplete,
	input wire logic      sleepExec,
	input wire logic      instrRetired,
	input wire logic      globalIrqEnable,
	input wire logic      periphIrqEnable,
	input wire logic      convDoneFlag,
	input wire logic      convDoneIrqEnable,
	input wire adw_sw_s   swAccess,
	input wire adw_core_s coreCtrl
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_wake;
		coreCtrl.wakeRequest && coreCtrl.fetchNext && !coreCtrl.asleep;
	endsequence
	property p_set; convComplete |=> convDoneFlag; endproperty
	a_set: assert property (p_set)
		else $error("flag not set");
	property p_hold; convDoneFlag && !(swAccess.flagWrite && !swAccess.flagData) |=> convDoneFlag;
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag lost");
	property p_irq; coreCtrl.irqRequest == $past(convDoneFlag && convDoneIrqEnable); endproperty
	a_irq: assert property (p_irq)
		else $error("bad request");
	property p_wake; coreCtrl.asleep && convDoneFlag && convDoneIrqEnable |=> s_wake; endproperty
	a_wake: assert property (p_wake)
		else $error("no wake");
	property p_pulse; coreCtrl.wakeRequest |=> !coreCtrl.wakeRequest; endproperty
	a_pulse: assert property (p_pulse)
		else $error("wake too long");
	property p_next; coreCtrl.fetchNext |-> !coreCtrl.vectorToIsr; endproperty
	a_next: assert property (p_next)
		else $error("vector before next");
	property p_next_hold; coreCtrl.fetchNext && !instrRetired |=> coreCtrl.fetchNext; endproperty
	a_next_hold: assert property (p_next_hold)
		else $error("next instruction skipped");
	property p_vec_gate; coreCtrl.vectorToIsr |-> $past(globalIrqEnable) &&
		$past(periphIrqEnable) && $past(convDoneFlag && convDoneIrqEnable);
	endproperty
	a_vec_gate: assert property (p_vec_gate)
		else $error("vector without enables");
	property p_vec; coreCtrl.vectorToIsr && $past(coreCtrl.fetchNext) |->
		$past(instrRetired) && $past(globalIrqEnable);
	endproperty
	a_vec: assert property (p_vec)
		else $error("bad vector");
	property p_inline; instrRetired && !globalIrqEnable |=> !coreCtrl.vectorToIsr; endproperty
	a_inline: assert property (p_inline)
		else $error("vector while disabled");
endmodule
bind adw_conv_done_irq adw_conv_done_irq_chk i_chk (
	.core_clk          (core_clk),
	.sys_rst           (sys_rst),
	.convComplete      (convComplete),
	.sleepExec         (sleepExec),
	.instrRetired      (instrRetired),
	.globalIrqEnable   (globalIrqEnable),
	.periphIrqEnable   (periphIrqEnable),
	.convDoneFlag      (convDoneFlag),
	.convDoneIrqEnable (convDoneIrqEnable),
	.swAccess          (swAccess),
	.coreCtrl          (coreCtrl)
);
`default_nettype wire

// [test/tb_adw_conv_done_irq.sv]
// Testbench for the conversion-done interrupt and wake block
`timescale 1ns/100ps
`default_nettype none
module tb_adw_conv_done_irq;
	import adw_pkg::*;
	logic core_clk = 0, sys_rst = 1, convComplete = 0, globalIrqEnable = 0, goSleep = 0;
	logic periphIrqEnable = 1;
	logic sleepExec, instrRetired, convDoneFlag, convDoneIrqEnable;
	adw_sw_s swAccess = '0;
	adw_core_s coreCtrl;
	int num_errors = 0, cmp_count = 0, seed = 32'h118B74C3, mf = 0, me = 0, mi = 0;
	int i, g, k, nw, nv, nf;
	always #12.5 core_clk = ~core_clk;
	adw_conv_done_irq i_adw_conv_done_irq (
		.core_clk          (core_clk),
		.sys_rst           (sys_rst),
		.convComplete      (convComplete),
		.swAccess          (swAccess),
		.sleepExec         (sleepExec),
		.instrRetired      (instrRetired),
		.globalIrqEnable   (globalIrqEnable),
		.periphIrqEnable   (periphIrqEnable),
		.convDoneFlag      (convDoneFlag),
		.convDoneIrqEnable (convDoneIrqEnable),
		.coreCtrl          (coreCtrl)
	);
	adw_core_model i_adw_core_model (.core_clk, .goSleep, .fetchNext(coreCtrl.fetchNext),
		.sleepExec, .instrRetired);
	// Registered strobes, so sampling at the edge sees the last cycle
	always @(posedge core_clk) begin
		nw += coreCtrl.wakeRequest;
		nv += coreCtrl.vectorToIsr;
		nf += coreCtrl.fetchNext;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task give_verdict;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge core_clk);
		sys_rst = 0;
		for (i = 0; i < 400; i++) begin
			@(negedge core_clk);
			chk(convDoneFlag, 8'(mf));
			chk(coreCtrl.irqRequest, 8'(mi));
			chk(convDoneIrqEnable, 8'(me));
			{convComplete, swAccess} = 5'($random(seed));
			mi = mf & me;
			if (swAccess.flagWrite) mf = swAccess.flagData;
			if (convComplete) mf = 1;
			if (swAccess.enableWrite) me = swAccess.enableData;
		end
		// Sleep with global off, sleep with global on, then awake with global on
		for (g = 0; g < 3; g++) begin
			@(negedge core_clk);
			{convComplete, swAccess} = 5'h0B;
			@(negedge core_clk);
			swAccess = '0;
			globalIrqEnable = (g != 0);
			goSleep = (g < 2);
			@(negedge core_clk);
			goSleep = 0;
			nw = 0;
			nv = 0;
			nf = 0;
			repeat (3) @(negedge core_clk);
			chk(coreCtrl.asleep, 8'(g < 2));
			convComplete = 1;
			@(negedge core_clk);
			convComplete = 0;
			// Entering the service routine drops the global enable
			for (k = 0; k < 10; k++) begin
				@(negedge core_clk);
				if (coreCtrl.vectorToIsr === 1'b1) globalIrqEnable = 0;
			end
			chk(convDoneFlag, 8'h01);
			chk(8'(nw), 8'(g < 2));
			chk(8'(nf), (g < 2) ? 8'h02 : 8'h00);
			chk(8'(nv), 8'(g != 0));
			globalIrqEnable = 0;
		end
		give_verdict();
	end
endmodule
`default_nettype wire
